// [src/tpe_pkg.sv]
package tpe_pkg;
   // AXI4-Lite register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_PRS0   = 8'h04;
   localparam logic [7:0] ADDR_PRS1   = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_CNT0   = 8'h10;
   localparam logic [7:0] ADDR_CNT1   = 8'h14;

   // Control register fields
   localparam int CTRL_RUN0   = 0;
   localparam int CTRL_RUN1   = 1;
   localparam int CTRL_BEDGE  = 2;
   localparam int CTRL_TOUSE  = 3;
   localparam int CTRL_PORTD  = 4;
   localparam int CTRL_W      = 5;
   localparam logic [4:0] CTRL_RST = 5'h00;

   // Prescaler selection fields
   localparam int PRS_W       = 6;
   localparam int PRS_CLK_LO  = 0;
   localparam int PRS_EA_LO   = 2;
   localparam int PRS_EB_LO   = 4;
   localparam logic [5:0] PRS_RST = 6'h00;

   // Count clock choices
   localparam logic [1:0] CLK_DIV2  = 2'h0;
   localparam logic [1:0] CLK_DIV8  = 2'h1;
   localparam logic [1:0] CLK_DIV32 = 2'h2;
   localparam logic [1:0] CLK_EXT   = 2'h3;

   // Valid-edge choices
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_NONE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Status register fields
   localparam int ST_REF0  = 0;
   localparam int ST_REF1  = 1;
   localparam int ST_NG0   = 2;
   localparam int ST_NG1   = 3;
   localparam int ST_CS0   = 4;
   localparam int ST_CS1   = 5;
   localparam int ST_PINC  = 6;
   localparam int ST_W     = 7;

   localparam int DIV_W    = 5;
   localparam int CNT_W    = 16;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [src/tpe_edge_det.sv]
`timescale 1ns/1ps
module tpe_edge_det (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       sample_en,
   input  wire logic       pin,
   input  wire logic       run,
   input  wire logic [1:0] edge_sel,
   output logic            edge_pulse
);
   logic smp_q;
   logic lvl_q;
   logic prev_q;
   logic armed_q;
   logic rise;
   logic fall;

   ////////////////////////////////////////////////////////////////////////
   // Noise filter: level moves only after two equal samples
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         smp_q <= 1'b0;
         lvl_q <= 1'b0;
      end else if (sample_en) begin
         smp_q <= pin;
         if (pin == smp_q) begin
            lvl_q <= pin;
         end
      end
   end

   // Before the first run the old level stays low, so a pin pulled high
   // since reset shows as a rising edge; afterwards it tracks the pin.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prev_q  <= 1'b0;
         armed_q <= 1'b0;
      end else begin
         if (run) begin
            armed_q <= 1'b1;
         end
         if (run || armed_q) begin
            prev_q <= lvl_q;
         end
      end
   end

   assign rise = lvl_q & ~prev_q;
   assign fall = ~lvl_q & prev_q;
   assign edge_pulse = run &
      ((rise & (edge_sel == tpe_pkg::EDGE_RISE ||
                edge_sel == tpe_pkg::EDGE_BOTH)) |
       (fall & (edge_sel == tpe_pkg::EDGE_FALL ||
                edge_sel == tpe_pkg::EDGE_BOTH)));

   ////////////////////////////////////////////////////////////////////////
   property p_first_rise;
      @(posedge clk) disable iff (!resetn)
      (run && !armed_q && lvl_q && edge_sel == tpe_pkg::EDGE_RISE)
         |-> edge_pulse;
   endproperty
   a_first_rise: assert property (p_first_rise)
      else $error("high pin at first enable gave no rising edge");

   property p_reenable_quiet;
      @(posedge clk) disable iff (!resetn)
      (!run && armed_q && lvl_q) ##1 (run && $stable(lvl_q))
         |-> !edge_pulse;
   endproperty
   a_reenable_quiet: assert property (p_reenable_quiet)
      else $error("edge seen only because pin high at re-enable");

   property p_filter_hold;
      @(posedge clk) disable iff (!resetn)
      !sample_en |=> $stable(lvl_q);
   endproperty
   a_filter_hold: assert property (p_filter_hold)
      else $error("filtered level moved without a sample");
endmodule

// [src/tpe_top.sv]
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
// How it works
// - Internal oscillator divided gives count clock when it feeds the processor
// - Inputs filtered by sampling clock
// - High pin after reset: rising edge on enable
// - High pin at re-enable: no edge
// - Second input edge use gives way to timer output use
// - Timer output use blocks second input edge
module tpe_top (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        cpu_on_int_osc,
   input  wire logic        int_osc_tick,
   input  wire logic        capture_input_a_ch0,
   input  wire logic        capture_input_b_ch0,
   input  wire logic        capture_input_a_ch1,
   input  wire logic        clear_start_a_ch0,
   input  wire logic        clear_start_a_ch1,
   input  wire logic        timer_out_level_ch0,
   output logic             shared_port_pin_o,
   output logic             shared_port_pin_oe,
   output logic             count_tick_ch0,
   output logic             count_tick_ch1,
   output logic             capture_b_edge_ch0
);
   logic [tpe_pkg::CTRL_W-1:0] ctrl_q;
   logic [tpe_pkg::PRS_W-1:0]  prescale_select_ch0;
   logic [tpe_pkg::PRS_W-1:0]  prescale_select_ch1;
   logic [1:0]                 refused_q;
   logic [tpe_pkg::DIV_W-1:0]  div_q;
   logic [tpe_pkg::CNT_W-1:0]  counter_ch0;
   logic [tpe_pkg::CNT_W-1:0]  counter_ch1;
   logic [7:0]                 awaddr_q;
   logic                       aw_held_q;
   logic [31:0]                wdata_q;
   logic                       wlow_q;
   logic                       w_held_q;
   logic                       do_write;
   logic                       step;
   logic                       run0;
   logic                       run1;
   logic                       b_edge_en;
   logic                       edge_a0;
   logic                       edge_a1;
   logic                       edge_b0;
   logic [tpe_pkg::ST_W-1:0]   status;
   logic [31:0]                rdata_d;
   logic                       rmapped;

   function automatic logic div_tick(input logic [1:0] sel,
                                     input logic [4:0] cnt,
                                     input logic       stp);
      unique case (sel)
         tpe_pkg::CLK_DIV2:  div_tick = stp & (cnt[0] == 1'b1);
         tpe_pkg::CLK_DIV8:  div_tick = stp & (cnt[2:0] == 3'h7);
         tpe_pkg::CLK_DIV32: div_tick = stp & (cnt == 5'h1F);
         tpe_pkg::CLK_EXT:   div_tick = 1'b0;
      endcase
   endfunction

   assign run0      = ctrl_q[tpe_pkg::CTRL_RUN0];
   assign run1      = ctrl_q[tpe_pkg::CTRL_RUN1];
   // Timer output use wins over edge use of the shared pin
   assign b_edge_en = ctrl_q[tpe_pkg::CTRL_BEDGE] &
                      ~ctrl_q[tpe_pkg::CTRL_TOUSE];

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path: address and data taken in either order
   assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
   assign do_write      = aw_held_q & w_held_q & ~s_axi_bvalid;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0000_0000;
         wlow_q    <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wlow_q   <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= tpe_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         unique case (awaddr_q)
            tpe_pkg::ADDR_CTRL, tpe_pkg::ADDR_PRS0,
            tpe_pkg::ADDR_PRS1, tpe_pkg::ADDR_STATUS:
               s_axi_bresp <= tpe_pkg::RESP_OKAY;
            default: s_axi_bresp <= tpe_pkg::RESP_SLVERR;
         endcase
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers; a prescaler write while the channel runs is dropped and
   // flagged, since a clock change mid-count would corrupt the count.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q              <= tpe_pkg::CTRL_RST;
         prescale_select_ch0 <= tpe_pkg::PRS_RST;
         prescale_select_ch1 <= tpe_pkg::PRS_RST;
      end else if (do_write && wlow_q) begin
         if (awaddr_q == tpe_pkg::ADDR_CTRL) begin
            ctrl_q <= wdata_q[tpe_pkg::CTRL_W-1:0];
         end
         if (awaddr_q == tpe_pkg::ADDR_PRS0 && !run0) begin
            prescale_select_ch0 <= wdata_q[tpe_pkg::PRS_W-1:0];
         end
         if (awaddr_q == tpe_pkg::ADDR_PRS1 && !run1) begin
            prescale_select_ch1 <= wdata_q[tpe_pkg::PRS_W-1:0];
         end
      end
   end

   // Sticky refusal flags; a new refusal wins over a clearing write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         refused_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (do_write && wlow_q &&
                awaddr_q == (i == 0 ? tpe_pkg::ADDR_PRS0
                                    : tpe_pkg::ADDR_PRS1) &&
                (i == 0 ? run0 : run1)) begin
               refused_q[i] <= 1'b1;
            end else if (do_write && wlow_q &&
                         awaddr_q == tpe_pkg::ADDR_STATUS &&
                         wdata_q[tpe_pkg::ST_REF0 + i]) begin
               refused_q[i] <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Count clock: the shared divider steps on the internal oscillator
   // tick when that oscillator feeds the processor.
   assign step = cpu_on_int_osc ? int_osc_tick : 1'b1;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_q <= 5'h00;
      end else if (step) begin
         div_q <= div_q + 5'h01;
      end
   end

   tpe_edge_det u_edge_a0 (
      .clk        (clk),
      .resetn     (resetn),
      .sample_en  (step),
      .pin        (capture_input_a_ch0),
      .run        (run0),
      .edge_sel   (prescale_select_ch0[tpe_pkg::PRS_EA_LO +: 2]),
      .edge_pulse (edge_a0)
   );

   tpe_edge_det u_edge_a1 (
      .clk        (clk),
      .resetn     (resetn),
      .sample_en  (step),
      .pin        (capture_input_a_ch1),
      .run        (run1),
      .edge_sel   (prescale_select_ch1[tpe_pkg::PRS_EA_LO +: 2]),
      .edge_pulse (edge_a1)
   );

   tpe_edge_det u_edge_b0 (
      .clk        (clk),
      .resetn     (resetn),
      .sample_en  (step),
      .pin        (capture_input_b_ch0),
      .run        (run0 & b_edge_en),
      .edge_sel   (prescale_select_ch0[tpe_pkg::PRS_EB_LO +: 2]),
      .edge_pulse (edge_b0)
   );

   assign count_tick_ch0 = run0 &
      (prescale_select_ch0[1:0] == tpe_pkg::CLK_EXT ? edge_a0 :
       div_tick(prescale_select_ch0[1:0], div_q, step));
   assign count_tick_ch1 = run1 &
      (prescale_select_ch1[1:0] == tpe_pkg::CLK_EXT ? edge_a1 :
       div_tick(prescale_select_ch1[1:0], div_q, step));
   assign capture_b_edge_ch0 = edge_b0;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         counter_ch0 <= 16'h0000;
         counter_ch1 <= 16'h0000;
      end else begin
         if (count_tick_ch0) begin
            counter_ch0 <= counter_ch0 + 16'h0001;
         end
         if (count_tick_ch1) begin
            counter_ch1 <= counter_ch1 + 16'h0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shared port pin: timer output when timer output use is set, undriven
   // while the second input does edge detection, otherwise plain port data.
   assign shared_port_pin_oe = ctrl_q[tpe_pkg::CTRL_TOUSE] | ~b_edge_en;
   assign shared_port_pin_o  = (ctrl_q[tpe_pkg::CTRL_TOUSE] & ~b_edge_en)
      ? timer_out_level_ch0 : ctrl_q[tpe_pkg::CTRL_PORTD];

   ////////////////////////////////////////////////////////////////////////
   // Status and read path
   always_comb begin
      status = '0;
      status[tpe_pkg::ST_REF0] = refused_q[0];
      status[tpe_pkg::ST_REF1] = refused_q[1];
      status[tpe_pkg::ST_NG0]  = cpu_on_int_osc & run0;
      status[tpe_pkg::ST_NG1]  = cpu_on_int_osc & run1;
      status[tpe_pkg::ST_CS0]  = clear_start_a_ch0 &
         (prescale_select_ch0[1:0] == tpe_pkg::CLK_EXT);
      status[tpe_pkg::ST_CS1]  = clear_start_a_ch1 &
         (prescale_select_ch1[1:0] == tpe_pkg::CLK_EXT);
      status[tpe_pkg::ST_PINC] = ctrl_q[tpe_pkg::CTRL_BEDGE] &
                                 ctrl_q[tpe_pkg::CTRL_TOUSE];
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      rmapped = 1'b1;
      unique case (s_axi_araddr)
         tpe_pkg::ADDR_CTRL:   rdata_d[tpe_pkg::CTRL_W-1:0] = ctrl_q;
         tpe_pkg::ADDR_PRS0:   rdata_d[tpe_pkg::PRS_W-1:0] =
                                  prescale_select_ch0;
         tpe_pkg::ADDR_PRS1:   rdata_d[tpe_pkg::PRS_W-1:0] =
                                  prescale_select_ch1;
         tpe_pkg::ADDR_STATUS: rdata_d[tpe_pkg::ST_W-1:0] = status;
         tpe_pkg::ADDR_CNT0:   rdata_d[tpe_pkg::CNT_W-1:0] = counter_ch0;
         tpe_pkg::ADDR_CNT1:   rdata_d[tpe_pkg::CNT_W-1:0] = counter_ch1;
         default:              rmapped = 1'b0;
      endcase
   end

   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= tpe_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdata_d;
         s_axi_rresp  <= rmapped ? tpe_pkg::RESP_OKAY
                                 : tpe_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_prs0_write_running;
      do_write && wlow_q && awaddr_q == tpe_pkg::ADDR_PRS0 && run0;
   endsequence

   property p_prs0_locked;
      @(posedge clk) disable iff (!resetn)
      s_prs0_write_running |=> $stable(prescale_select_ch0) &&
                               refused_q[0] && s_axi_bvalid;
   endproperty
   a_prs0_locked: assert property (p_prs0_locked)
      else $error("ch0 prescaler changed while running");

   property p_prs1_locked;
      @(posedge clk) disable iff (!resetn)
      (do_write && wlow_q && awaddr_q == tpe_pkg::ADDR_PRS1 && run1)
         |=> $stable(prescale_select_ch1) && refused_q[1];
   endproperty
   a_prs1_locked: assert property (p_prs1_locked)
      else $error("ch1 prescaler changed while running");

   property p_osc_step;
      @(posedge clk) disable iff (!resetn)
      (cpu_on_int_osc && !int_osc_tick) |=> $stable(div_q);
   endproperty
   a_osc_step: assert property (p_osc_step)
      else $error("divider ran without oscillator tick");

   property p_ext_clock;
      @(posedge clk) disable iff (!resetn)
      (run0 && prescale_select_ch0[1:0] == tpe_pkg::CLK_EXT)
         |-> count_tick_ch0 == edge_a0;
   endproperty
   a_ext_clock: assert property (p_ext_clock)
      else $error("ch0 count clock not the pin edge");

   property p_div2_rate;
      @(posedge clk) disable iff (!resetn)
      (count_tick_ch1 && !cpu_on_int_osc &&
       prescale_select_ch1[1:0] == tpe_pkg::CLK_DIV2)
         |=> !count_tick_ch1;
   endproperty
   a_div2_rate: assert property (p_div2_rate)
      else $error("divide-by-two ticked twice in a row");

   property p_no_tout_on_edge;
      @(posedge clk) disable iff (!resetn)
      b_edge_en |-> shared_port_pin_o == ctrl_q[tpe_pkg::CTRL_PORTD];
   endproperty
   a_no_tout_on_edge: assert property (p_no_tout_on_edge)
      else $error("timer output on pin during edge use");

   property p_no_edge_on_tout;
      @(posedge clk) disable iff (!resetn)
      ctrl_q[tpe_pkg::CTRL_TOUSE] |-> !capture_b_edge_ch0;
   endproperty
   a_no_edge_on_tout: assert property (p_no_edge_on_tout)
      else $error("second input edge while timer output used");

   property p_ng_flag;
      @(posedge clk) disable iff (!resetn)
      (cpu_on_int_osc && run0) |-> status[tpe_pkg::ST_NG0];
   endproperty
   a_ng_flag: assert property (p_ng_flag)
      else $error("unguaranteed-operation flag missing");

   property p_cs_flag;
      @(posedge clk) disable iff (!resetn)
      (clear_start_a_ch1 &&
       prescale_select_ch1[1:0] == tpe_pkg::CLK_EXT)
         |-> status[tpe_pkg::ST_CS1];
   endproperty
   a_cs_flag: assert property (p_cs_flag)
      else $error("ch1 clear-start conflict not flagged");
endmodule

// [tb/tpe_tb.sv]
`timescale 1ns/1ps
module testbench;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        on_osc = 1'b0;
   logic        osc_tick = 1'b0;
   logic [1:0]  osc_div = 2'h0;
   // Pin a ch0 is high from time zero for the after-reset edge case
   logic [2:0]  pin = 3'h1;
   logic [1:0]  clr_start = 2'h0;
   logic        tout_lvl = 1'b0;
   logic        pin_o, pin_oe, tick0, tick1, bedge;
   int          n0, n1, nb, base, err_total, comparisons;

   tpe_top DUT (
      .clk                (clk),
      .resetn             (resetn),
      .s_axi_awaddr       (s_axi_awaddr),
      .s_axi_awvalid      (s_axi_awvalid),
      .s_axi_awready      (awready),
      .s_axi_wdata        (s_axi_wdata),
      .s_axi_wstrb        (4'hF),
      .s_axi_wvalid       (s_axi_wvalid),
      .s_axi_wready       (wready),
      .s_axi_bresp        (bresp),
      .s_axi_bvalid       (bvalid),
      .s_axi_bready       (s_axi_bready),
      .s_axi_araddr       (s_axi_araddr),
      .s_axi_arvalid      (s_axi_arvalid),
      .s_axi_arready      (arready),
      .s_axi_rdata        (rdata),
      .s_axi_rresp        (rresp),
      .s_axi_rvalid       (rvalid),
      .s_axi_rready       (s_axi_rready),
      .cpu_on_int_osc     (on_osc),
      .int_osc_tick       (osc_tick),
      .capture_input_a_ch0(pin[0]),
      .capture_input_b_ch0(pin[1]),
      .capture_input_a_ch1(pin[2]),
      .clear_start_a_ch0  (clr_start[0]),
      .clear_start_a_ch1  (clr_start[1]),
      .timer_out_level_ch0(tout_lvl),
      .shared_port_pin_o  (pin_o),
      .shared_port_pin_oe (pin_oe),
      .count_tick_ch0     (tick0),
      .count_tick_ch1     (tick1),
      .capture_b_edge_ch0 (bedge)
   );

   always #50 clk = ~clk;

   always @(posedge clk) begin
      osc_div <= osc_div + 2'h1;
      osc_tick <= (osc_div == 2'h3);
   end

   // Pulses are counted at the falling edge, where they have settled
   initial begin
      n0 = 0;
      n1 = 0;
      nb = 0;
   end
   always @(negedge clk) begin
      if (tick0 === 1'b1) n0++;
      if (tick1 === 1'b1) n1++;
      if (bedge === 1'b1) nb++;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      if (err_total == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awvalid && awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 40);
      s_axi_bready <= 1'b0;
      check(bresp, er);
      if (n >= 40) begin
         err_total++;
         final_report();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 40);
      s_axi_rready <= 1'b0;
      check(rdata, ed);
      check(rresp, er);
      if (n >= 40) begin
         err_total++;
         final_report();
      end
   endtask

   // Pulses are high for w cycles, then low for 8 so the two-sample filter settles low
   task automatic pulse_pin(input int i, input int cnt, input int w);
      for (int k = 0; k < cnt; k++) begin
         @(posedge clk);
         pin[i] <= 1'b1;
         repeat (w) @(posedge clk);
         pin[i] <= 1'b0;
         repeat (8) @(posedge clk);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      err_total = 0;
      comparisons = 0;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      check(pin_oe, 1'b1);
      check(pin_o, 1'b0);
      rd(tpe_pkg::ADDR_CTRL, 32'h0, tpe_pkg::RESP_OKAY);
      rd(tpe_pkg::ADDR_PRS1, 32'h0, tpe_pkg::RESP_OKAY);
      rd(tpe_pkg::ADDR_STATUS, 32'h0, tpe_pkg::RESP_OKAY);
      rd(8'h20, 32'h0, tpe_pkg::RESP_SLVERR);
      wr(8'h20, 32'h1, tpe_pkg::RESP_SLVERR);
      // Pin edge count clock, rising edge, pin high since reset
      wr(tpe_pkg::ADDR_PRS0, 32'h27, tpe_pkg::RESP_OKAY);
      wr(tpe_pkg::ADDR_CTRL, 32'h1, tpe_pkg::RESP_OKAY);
      repeat (8) @(posedge clk);
      check(n0, 1);
      wr(tpe_pkg::ADDR_CTRL, 32'h0, tpe_pkg::RESP_OKAY);
      wr(tpe_pkg::ADDR_CTRL, 32'h1, tpe_pkg::RESP_OKAY);
      repeat (8) @(posedge clk);
      check(n0, 1);
      pin[0] <= 1'b0;
      repeat (8) @(posedge clk);
      pulse_pin(0, 3, 8);
      check(n0, 4);
      pulse_pin(0, 1, 1);
      check(n0, 4);
      rd(tpe_pkg::ADDR_CNT0, 32'h4, tpe_pkg::RESP_OKAY);
      // Prescale writes while running are dropped and flagged
      wr(tpe_pkg::ADDR_PRS0, 32'h0, tpe_pkg::RESP_OKAY);
      rd(tpe_pkg::ADDR_PRS0, 32'h27, tpe_pkg::RESP_OKAY);
      rd(tpe_pkg::ADDR_STATUS, 32'h1, tpe_pkg::RESP_OKAY);
      wr(tpe_pkg::ADDR_CTRL, 32'h3, tpe_pkg::RESP_OKAY);
      wr(tpe_pkg::ADDR_PRS1, 32'h1, tpe_pkg::RESP_OKAY);
      rd(tpe_pkg::ADDR_PRS1, 32'h0, tpe_pkg::RESP_OKAY);
      rd(tpe_pkg::ADDR_STATUS, 32'h3, tpe_pkg::RESP_OKAY);
      wr(tpe_pkg::ADDR_STATUS, 32'h3, tpe_pkg::RESP_OKAY);
      rd(tpe_pkg::ADDR_STATUS, 32'h0, tpe_pkg::RESP_OKAY);
      // Clear-and-start on the pin that also clocks the counter
      wr(tpe_pkg::ADDR_CTRL, 32'h0, tpe_pkg::RESP_OKAY);
      wr(tpe_pkg::ADDR_PRS1, 32'h3, tpe_pkg::RESP_OKAY);
      wr(tpe_pkg::ADDR_CTRL, 32'h3, tpe_pkg::RESP_OKAY);
      clr_start <= 2'h3;
      rd(tpe_pkg::ADDR_STATUS, 32'h30, tpe_pkg::RESP_OKAY);
      clr_start <= 2'h0;
      wr(tpe_pkg::ADDR_CTRL, 32'h0, tpe_pkg::RESP_OKAY);
      // Divided clocks: 64 cycles hold an exact number of periods
      for (int k = 0; k < 3; k++) begin
         wr(tpe_pkg::ADDR_PRS1, k, tpe_pkg::RESP_OKAY);
         wr(tpe_pkg::ADDR_CTRL, 32'h2, tpe_pkg::RESP_OKAY);
         base = n1;
         repeat (64) @(posedge clk);
         check(n1 - base, 32 >> (2 * k));
         wr(tpe_pkg::ADDR_CTRL, 32'h0, tpe_pkg::RESP_OKAY);
      end
      on_osc <= 1'b1;
      wr(tpe_pkg::ADDR_PRS1, 32'h0, tpe_pkg::RESP_OKAY);
      wr(tpe_pkg::ADDR_CTRL, 32'h2, tpe_pkg::RESP_OKAY);
      base = n1;
      repeat (64) @(posedge clk);
      check(n1 - base, 8);
      rd(tpe_pkg::ADDR_STATUS, 32'h8, tpe_pkg::RESP_OKAY);
      wr(tpe_pkg::ADDR_CTRL, 32'h0, tpe_pkg::RESP_OKAY);
      on_osc <= 1'b0;
      // Shared pin: second input edge against timer output
      wr(tpe_pkg::ADDR_PRS0, 32'h10, tpe_pkg::RESP_OKAY);
      wr(tpe_pkg::ADDR_CTRL, 32'h5, tpe_pkg::RESP_OKAY);
      check(pin_oe, 1'b0);
      base = nb;
      pulse_pin(1, 2, 8);
      check(nb - base, 2);
      wr(tpe_pkg::ADDR_CTRL, 32'hD, tpe_pkg::RESP_OKAY);
      check(pin_oe, 1'b1);
      check(pin_o, 1'b0);
      // Level is set only once the output mode is in place
      tout_lvl <= 1'b1;
      @(posedge clk);
      check(pin_o, 1'b1);
      base = nb;
      pulse_pin(1, 2, 8);
      check(nb - base, 0);
      rd(tpe_pkg::ADDR_STATUS, 32'h40, tpe_pkg::RESP_OKAY);
      tout_lvl <= 1'b0;
      wr(tpe_pkg::ADDR_CTRL, 32'h10, tpe_pkg::RESP_OKAY);
      check(pin_oe, 1'b1);
      check(pin_o, 1'b1);
      // Mid-run reset: a pin held high must edge again at the first run
      resetn <= 1'b0;
      pin[0] <= 1'b1;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      rd(tpe_pkg::ADDR_CTRL, 32'h0, tpe_pkg::RESP_OKAY);
      wr(tpe_pkg::ADDR_PRS0, 32'h27, tpe_pkg::RESP_OKAY);
      base = n0;
      wr(tpe_pkg::ADDR_CTRL, 32'h1, tpe_pkg::RESP_OKAY);
      repeat (8) @(posedge clk);
      check(n0 - base, 1);
      final_report();
   end
endmodule
